/* hw/apo_fifo.sv */
// Dual-clock FIFO with gray pointers and registered read data
`timescale 1ns/1ps
module apo_fifo #(
  parameter int W = 33,
  parameter int D = 8
) (
  input wire logic    wclk_in,
  input wire logic    wrst_n_in,
  input wire logic    rclk_in,
  input wire logic    rrst_n_in,
  apo_stream_if.snk   wr,
  apo_stream_if.src   rd
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wbin_q;
  logic [AW:0]  wgray_q;
  logic [AW:0]  rbin_q;
  logic [AW:0]  rgray_q;
  logic [AW:0]  rg1_q;
  logic [AW:0]  rg2_q;
  logic [AW:0]  wg1_q;
  logic [AW:0]  wg2_q;
  logic [W-1:0] odata_q;
  logic         ovalid_q;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  wire [AW:0] wbin_d = wbin_q + (AW+1)'(1);
  wire [AW:0] rbin_d = rbin_q + (AW+1)'(1);
  // Full: pointers one lap apart, top two gray bits inverted
  wire        full   = (wgray_q == {~rg2_q[AW:AW-1], rg2_q[AW-2:0]});
  wire        empty  = (rgray_q == wg2_q);
  wire        push   = wr.valid && !full;
  wire        load   = !empty && (!ovalid_q || rd.ready);

  assign wr.ready = !full;
  assign rd.valid = ovalid_q;
  assign rd.data  = odata_q;

  always_ff @(posedge wclk_in) begin
    if (!wrst_n_in) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg1_q   <= '0;
      rg2_q   <= '0;
    end else begin
      rg1_q <= rgray_q;
      rg2_q <= rg1_q;
      if (push) begin
        wbin_q  <= wbin_d;
        wgray_q <= to_gray(wbin_d);
      end
    end
  end

  always_ff @(posedge wclk_in) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge rclk_in) begin
    if (!rrst_n_in) begin
      rbin_q   <= '0;
      rgray_q  <= '0;
      wg1_q    <= '0;
      wg2_q    <= '0;
      ovalid_q <= 1'b0;
      odata_q  <= '0;
    end else begin
      wg1_q <= wgray_q;
      wg2_q <= wg1_q;
      if (load) begin
        rbin_q   <= rbin_d;
        rgray_q  <= to_gray(rbin_d);
        odata_q  <= mem_q[rbin_q[AW-1:0]];
        ovalid_q <= 1'b1;
      end else if (rd.ready) begin
        ovalid_q <= 1'b0;
      end
    end
  end
endmodule

/* hw/apo_top.sv */
// Three-channel double-data-rate output port of the converter
// Summary of operation
// RULE_01 - Range flag high while input out of range
// RULE_02 - Forwarded clock runs at sampling clock over four; code divides lnk_clk_in by four instead
// RULE_03 - Receiver captures data on both clock edges
// RULE_04 - New word every two sampling clock cycles; code gives one every two lnk_clk_in cycles
// RULE_05 - Ten-bit word, bit 0 least significant
// RULE_06 - Every output has an inverted twin
// RULE_07 - Channel A clock is the data-ready strobe
// RULE_08 - Sample every channel on each rising edge; code holds the captured frame while the FIFO is full
// RULE_09 - Range flag aligned with its data word
`timescale 1ns/1ps
`include "apo_map.svh"
module apo_top (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   lnk_clk_in,
  input  wire logic [`APO_WORD_W-1:0] chan_a_sample_in,
  input  wire logic [`APO_WORD_W-1:0] chan_b_sample_in,
  input  wire logic [`APO_WORD_W-1:0] chan_c_sample_in,
  input  wire logic                   chan_a_over_in,
  input  wire logic                   chan_b_over_in,
  input  wire logic                   chan_c_over_in,
  output wire logic [`APO_WORD_W-1:0] chan_a_word_out,
  output wire logic [`APO_WORD_W-1:0] chan_a_word_inv_out,
  output wire logic [`APO_WORD_W-1:0] chan_b_word_out,
  output wire logic [`APO_WORD_W-1:0] chan_b_word_inv_out,
  output wire logic [`APO_WORD_W-1:0] chan_c_word_out,
  output wire logic [`APO_WORD_W-1:0] chan_c_word_inv_out,
  output wire logic                   chan_a_range_flag_out,
  output wire logic                   chan_a_range_flag_inv_out,
  output wire logic                   chan_b_range_flag_out,
  output wire logic                   chan_b_range_flag_inv_out,
  output wire logic                   chan_c_range_flag_out,
  output wire logic                   chan_c_range_flag_inv_out,
  output wire logic                   chan_a_fwd_clock_out,
  output wire logic                   chan_a_fwd_clock_inv_out,
  output wire logic                   chan_b_fwd_clock_out,
  output wire logic                   chan_b_fwd_clock_inv_out,
  output wire logic                   chan_c_fwd_clock_out,
  output wire logic                   chan_c_fwd_clock_inv_out
);
  localparam int FW = $bits(apo_pkg::apo_frame_t);

  apo_stream_if #(.W(FW)) wr_if ();
  apo_stream_if #(.W(FW)) rd_if ();

  // Sampling side, clk_in
  apo_pkg::apo_frame_t in1_q;
  apo_pkg::apo_frame_t in2_q;
  apo_pkg::apo_frame_t cap_q;
  logic                capv_q;

  wire apo_pkg::apo_frame_t pin_frame = '{
    a: '{flag: chan_a_over_in, word: chan_a_sample_in},
    b: '{flag: chan_b_over_in, word: chan_b_sample_in},
    c: '{flag: chan_c_over_in, word: chan_c_sample_in}
  };
  // Capture stalls while the FIFO is full, so no word is torn
  wire cap_load = !capv_q || wr_if.ready;

  assign wr_if.valid = capv_q;
  assign wr_if.data  = cap_q;

  // Pins cross in through two stages, untouched by logic
  always_ff @(posedge clk_in) begin
    in1_q <= pin_frame;
    in2_q <= in1_q;
  end

  // RULE_08 sample each edge, held while the FIFO is full
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cap_q  <= '0;
      capv_q <= 1'b0;
    end else if (cap_load) begin
      cap_q  <= in2_q;
      capv_q <= 1'b1;
    end
  end

  // Link side, lnk_clk_in
  logic                lrst1_q;
  logic                lrst_q;
  logic                ph_q;
  logic                fwd_q;
  logic                fwd_n_q;
  apo_pkg::apo_frame_t frame_q;
  apo_pkg::apo_frame_t frame_n_q;

  // Link clock runs free; reset is carried over by two stages
  always_ff @(posedge lnk_clk_in) begin
    lrst1_q <= rst_n_in;
    lrst_q  <= lrst1_q;
  end

  // Data changes in the slot between forwarded clock edges
  wire slot = !ph_q;
  wire pop  = slot && rd_if.valid;

  assign rd_if.ready = lrst_q && slot;

  wire apo_pkg::apo_frame_t rd_frame = rd_if.data;

  apo_fifo #(
    .W (FW),
    .D (`APO_FIFO_DEPTH)
  ) u_fifo (
    .wclk_in   (clk_in),
    .wrst_n_in (rst_n_in),
    .rclk_in   (lnk_clk_in),
    .rrst_n_in (lrst_q),
    .wr        (wr_if),
    .rd        (rd_if)
  );

  // RULE_02 divide by four
  always_ff @(posedge lnk_clk_in) begin
    if (!lrst_q) begin
      ph_q    <= 1'b0;
      fwd_q   <= `APO_FWD_RST;
      fwd_n_q <= ~`APO_FWD_RST;
    end else begin
      ph_q <= !ph_q;
      if (ph_q) begin
        fwd_q   <= !fwd_q;
        fwd_n_q <= fwd_q;
      end
    end
  end

  // RULE_04 word per two cycles
  // RULE_09 flag travels with word
  always_ff @(posedge lnk_clk_in) begin
    if (!lrst_q) begin
      frame_q   <= {3{`APO_FLAG_RST, `APO_WORD_RST}};
      frame_n_q <= ~{3{`APO_FLAG_RST, `APO_WORD_RST}};
    end else if (pop) begin
      frame_q   <= rd_if.data;
      frame_n_q <= ~rd_if.data;
    end
  end

  // RULE_05 lsb at index 0
  // RULE_06 complementary pairs
  assign chan_a_word_out           = frame_q.a.word;
  assign chan_a_word_inv_out       = frame_n_q.a.word;
  assign chan_b_word_out           = frame_q.b.word;
  assign chan_b_word_inv_out       = frame_n_q.b.word;
  assign chan_c_word_out           = frame_q.c.word;
  assign chan_c_word_inv_out       = frame_n_q.c.word;
  // RULE_01 flags from range inputs
  assign chan_a_range_flag_out     = frame_q.a.flag;
  assign chan_a_range_flag_inv_out = frame_n_q.a.flag;
  assign chan_b_range_flag_out     = frame_q.b.flag;
  assign chan_b_range_flag_inv_out = frame_n_q.b.flag;
  assign chan_c_range_flag_out     = frame_q.c.flag;
  assign chan_c_range_flag_inv_out = frame_n_q.c.flag;
  // RULE_07 channel A strobe
  assign chan_a_fwd_clock_out      = fwd_q;
  assign chan_a_fwd_clock_inv_out  = fwd_n_q;
  assign chan_b_fwd_clock_out      = fwd_q;
  assign chan_b_fwd_clock_inv_out  = fwd_n_q;
  assign chan_c_fwd_clock_out      = fwd_q;
  assign chan_c_fwd_clock_inv_out  = fwd_n_q;

  // Checks
  sequence s_clk_edge;
    $changed(fwd_q);
  endsequence

  sequence s_clk_hold;
    !$changed(fwd_q);
  endsequence

  a_cap_stall_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_08
    (capv_q && !wr_if.ready) |=> $stable(cap_q))
    else $error("Captured frame changed while stalled");

  a_cap_sample_take: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_08
    cap_load |=> (cap_q == $past(in2_q)))
    else $error("Captured frame does not match sampled pins");

  a_fwd_quarter_rate: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_02
    s_clk_edge |=> s_clk_hold ##1 s_clk_edge)
    else $error("Forwarded clock not at quarter rate");

  a_word_half_rate: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_04
    $changed(frame_q) |-> (!$changed(fwd_q) && $past(pop)))
    else $error("Word changed outside its slot");

  a_strobe_follows: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_07
    pop |=> s_clk_hold ##1 s_clk_edge)
    else $error("Strobe edge not one cycle after data");

  a_pair_levels: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_06
    (frame_n_q == ~frame_q) && (fwd_n_q == !fwd_q))
    else $error("Complementary pair mismatch");

  a_flag_aligned: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_09
    pop |=> (frame_q == $past(rd_if.data)))
    else $error("Flag and word not loaded together");

  a_range_follow: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_01
    (pop && rd_if.data[FW-1]) |=> chan_c_range_flag_out)
    else $error("Range flag lost");

  a_bit_order: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_05
    pop |=> (chan_a_word_out[0] == $past(rd_if.data[0])))
    else $error("Word bit order wrong");

  a_range_low: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_01
    (pop && !rd_frame.a.flag) |=> !chan_a_range_flag_out)
    else $error("Range flag high while in range");

  a_word_msb: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_05
    pop |=> (chan_b_word_out[`APO_WORD_W-1] == $past(rd_frame.b.word[`APO_WORD_W-1])))
    else $error("Word top bit misplaced");

  a_fwd_reset_idle: assert property (@(posedge lnk_clk_in) // RULE_02
    !lrst_q |=> (!ph_q && (fwd_q == `APO_FWD_RST) && (fwd_n_q == ~`APO_FWD_RST)))
    else $error("Forwarded clock not parked in reset");

  a_strobe_shared: assert property (@(posedge lnk_clk_in) disable iff (!lrst_q) // RULE_07
    (chan_b_fwd_clock_out == chan_a_fwd_clock_out) && (chan_c_fwd_clock_out == chan_a_fwd_clock_out))
    else $error("Channel clocks differ from channel A strobe");
endmodule

/* shared/apo_map.svh */
// Output port constants: widths, depths, reset values and rate limits
`ifndef APO_MAP_SVH
`define APO_MAP_SVH

`define APO_WORD_W        10
`define APO_FIFO_DEPTH    8
`define APO_FWD_MAX_MHZ   625
`define APO_LINE_MAX_MBPS 1250
`define APO_FWD_RST       1'h0
`define APO_WORD_RST      10'h000
`define APO_FLAG_RST      1'h0

`endif

/* shared/apo_pkg.sv */
// Types for the converter output port
`include "apo_map.svh"
package apo_pkg;

  typedef struct packed {
    logic                   flag;
    logic [`APO_WORD_W-1:0] word;
  } apo_chan_t;

  typedef struct packed {
    apo_chan_t c;
    apo_chan_t b;
    apo_chan_t a;
  } apo_frame_t;

endpackage

/* shared/apo_stream_if.sv */
// Valid/ready stream carrying one frame of three channel words
`timescale 1ns/1ps
interface apo_stream_if #(parameter int W = 33);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* testbench/apo_rx_model.sv */
// Receiver model latching one channel on both forwarded clock edges
`timescale 1ns/1ps
`include "apo_map.svh"
module apo_rx_model (
  input  wire logic                   fwd_in,
  input  wire logic [`APO_WORD_W-1:0] word_in,
  input  wire logic                   flag_in,
  output apo_pkg::apo_chan_t          cap_out
);
  always @(posedge fwd_in or negedge fwd_in) begin
    cap_out <= '{flag: flag_in, word: word_in};
  end
endmodule

/* testbench/tb_adc_ddr_output_port.sv */
// Self-checking bench for the three-channel output port
`timescale 1ns/1ps
`include "apo_map.svh"
module tb_adc_ddr_output_port;
  logic                   clk_in = 1'b0;
  logic                   lnk_clk_in = 1'b0;
  logic                   rst_n_in = 1'b0;
  logic [`APO_WORD_W-1:0] sa = 10'h000, sb = 10'h000, sc = 10'h000;
  logic                   oa = 1'b0, ob = 1'b0, oc = 1'b0;
  wire logic [`APO_WORD_W-1:0] wa, wai, wb, wbi, wc, wci;
  wire logic              fa, fai, fb, fbi, fc, fci, ka, kai, kb, kbi, kc, kci;
  apo_pkg::apo_chan_t     cap_a, cap_b, cap_c;
  int                     failures = 0;
  int                     num_checks = 0;
  int                     since_q = 0;
  bit                     mon_on = 1'b0;
  bit                     tog_q = 1'b0;
  logic                   ka_q = 1'b0;
  logic [`APO_WORD_W-1:0] wa_q = 10'h000;
  logic [`APO_WORD_W-1:0] corner [4] = '{10'h000, 10'h3ff, 10'h001, 10'h200};

  always #10 clk_in = ~clk_in;
  always #62.5 lnk_clk_in = ~lnk_clk_in;

  apo_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .lnk_clk_in(lnk_clk_in),
    .chan_a_sample_in(sa), .chan_b_sample_in(sb), .chan_c_sample_in(sc),
    .chan_a_over_in(oa), .chan_b_over_in(ob), .chan_c_over_in(oc),
    .chan_a_word_out(wa), .chan_a_word_inv_out(wai), .chan_b_word_out(wb),
    .chan_b_word_inv_out(wbi), .chan_c_word_out(wc), .chan_c_word_inv_out(wci),
    .chan_a_range_flag_out(fa), .chan_a_range_flag_inv_out(fai),
    .chan_b_range_flag_out(fb), .chan_b_range_flag_inv_out(fbi),
    .chan_c_range_flag_out(fc), .chan_c_range_flag_inv_out(fci),
    .chan_a_fwd_clock_out(ka), .chan_a_fwd_clock_inv_out(kai),
    .chan_b_fwd_clock_out(kb), .chan_b_fwd_clock_inv_out(kbi),
    .chan_c_fwd_clock_out(kc), .chan_c_fwd_clock_inv_out(kci));

  apo_rx_model rx_a (.fwd_in(ka), .word_in(wa), .flag_in(fa), .cap_out(cap_a));
  apo_rx_model rx_b (.fwd_in(kb), .word_in(wb), .flag_in(fb), .cap_out(cap_b));
  apo_rx_model rx_c (.fwd_in(kc), .word_in(wc), .flag_in(fc), .cap_out(cap_c));

  function automatic logic [10:0] exp_chan(input logic [9:0] w, input logic f);
    return {f, w};
  endfunction

  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Link outputs are settled by the falling link edge
  always @(negedge lnk_clk_in) begin
    ka_q <= ka;
    wa_q <= wa;
    since_q <= (ka !== ka_q) ? 1 : since_q + 1;
    tog_q <= mon_on && (tog_q || ka !== ka_q);
    if (mon_on) begin
      check("inv_a", {fai, wai}, ~{fa, wa});
      check("inv_b", {fbi, wbi}, ~{fb, wb});
      check("inv_c", {fci, wci}, ~{fc, wc});
      check("fwd_inv", {8'h00, kai, kbi, kci}, {8'h00, ~ka, ~kb, ~kc});
      check("fwd_same", {9'h000, kb, kc}, {9'h000, ka, ka});
      if (tog_q && ka !== ka_q)
        check("fwd_half", 11'(since_q), 11'h002);
      if (wa !== wa_q)
        check("word_slot", {10'h000, ka !== ka_q}, 11'h000);
    end
  end

  initial begin
    logic [9:0] va, vb, vc;
    logic [2:0] fl;
    void'($urandom(22241));
    repeat (12) @(posedge lnk_clk_in);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge lnk_clk_in);
    mon_on = 1'b1;
    // Corners first: all zeros, all ones, single LSB, single MSB
    for (int i = 0; i < 16; i++) begin
      va = (i < 4) ? corner[i] : 10'($urandom);
      vb = (i < 4) ? ~corner[i] : 10'($urandom);
      vc = (i < 4) ? corner[(i + 1) % 4] : 10'($urandom);
      fl = (i < 4) ? 3'(i * 3) : 3'($urandom);
      @(posedge clk_in);
      sa <= va;
      sb <= vb;
      sc <= vc;
      oa <= fl[0];
      ob <= fl[1];
      oc <= fl[2];
      // Long hold so the full FIFO drains stale frames
      repeat (250) @(posedge clk_in);
      @(negedge lnk_clk_in);
      check("cap_a", cap_a, exp_chan(va, fl[0]));
      check("cap_b", cap_b, exp_chan(vb, fl[1]));
      check("cap_c", cap_c, exp_chan(vc, fl[2]));
      check("live_a", {fa, wa}, exp_chan(va, fl[0]));
    end
    mon_on = 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (12) @(posedge lnk_clk_in);
    @(negedge lnk_clk_in);
    check("rst_true", {fa, wa}, 11'h000);
    check("rst_true_b", {fb, wb}, 11'h000);
    check("rst_true_c", {fc, wc}, 11'h000);
    check("rst_fwd", {8'h00, ka, kb, kc}, 11'h000);
    check("rst_inv", {fai, wai}, 11'h7ff);
    check("rst_fwd_inv", {8'h00, kai, kbi, kci}, 11'h007);
    end_of_test();
  end

  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
